/* verilog/ccw_pkg.sv */
/*
 * Constants for the cycle watch and clock pulse byte block: register map,
 * field positions, reset values, legal ranges, timing counts and states.
 * Assumes a 20 MHz system clock and a plain register port with byte addresses.
 */
package ccw_pkg;

    // Clock and base tick.
    localparam int CLK_KHZ        = 20000;
    localparam int TICK_MS        = 1;
    localparam int MS_TICK_CYCLES = CLK_KHZ * TICK_MS;
    localparam int UNIT_MS        = 100;
    localparam int COMM_WINDOW_MS = 100;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte addresses.
    localparam logic [7:0] A_CTRL     = 8'h00;
    localparam logic [7:0] A_CLK_BYTE = 8'h04;
    localparam logic [7:0] A_SCAN_LIM = 8'h08;
    localparam logic [7:0] A_COMM_PCT = 8'h0c;
    localparam logic [7:0] A_SELFTEST = 8'h10;
    localparam logic [7:0] A_PARAM_TO = 8'h14;
    localparam logic [7:0] A_READY_TO = 8'h18;
    localparam logic [7:0] A_STATUS   = 8'h1c;
    localparam logic [7:0] A_DIAG     = 8'h20;

    // Control fields.
    localparam int F_CPB_EN  = 0;
    localparam int F_HWTEST  = 1;
    localparam int F_START   = 2;

    // Diagnostic flag positions.
    localparam int D_SCAN    = 0;
    localparam int D_PARAM   = 1;
    localparam int D_READY   = 2;
    localparam int D_RAM     = 3;
    localparam int D_PROG    = 4;
    localparam int D_MODFAIL = 5;
    localparam int D_WIRE    = 6;
    localparam int D_NUM     = 7;

    // Reset values and legal ranges.
    localparam logic [7:0]  RST_CLK_BYTE = 8'h00;
    localparam logic [12:0] RST_SCAN_LIM = 13'h0096;
    localparam logic [12:0] MIN_SCAN_LIM = 13'h0001;
    localparam logic [12:0] MAX_SCAN_LIM = 13'h1770;
    localparam logic [5:0]  RST_COMM_PCT = 6'h14;
    localparam logic [5:0]  MIN_COMM_PCT = 6'h0a;
    localparam logic [5:0]  MAX_COMM_PCT = 6'h32;
    localparam logic [15:0] RST_PARAM_TO = 16'h0064;
    localparam logic [15:0] MIN_PARAM_TO = 16'h0001;
    localparam logic [15:0] MAX_PARAM_TO = 16'h2710;
    localparam logic [15:0] RST_READY_TO = 16'hfde8;
    localparam logic [15:0] MIN_READY_TO = 16'h0001;
    localparam logic [15:0] MAX_READY_TO = 16'hfde8;

    // Half periods in ms of the clock pulse bits, bit 7 first (periods 2 s down to 0.1 s).
    localparam logic [7:0][9:0] CPB_HALF_MS = {10'h3e8, 10'h320, 10'h1f4, 10'h190,
                                               10'h0fa, 10'h0c8, 10'h064, 10'h032};

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_RAMTEST = 3'h1,
        ST_PARAM   = 3'h2,
        ST_READY   = 3'h3,
        ST_RUN     = 3'h4,
        ST_STOP    = 3'h5
    } ccw_state_t;

endpackage

/* verilog/ccw_cycle_watch.sv */
/*
 * Controller supervision block: clock pulse byte written into a memory byte,
 * scan cycle watchdog, communication load cap, power-on startup sequencer
 * and sticky system diagnostics.
 * Assumes the memory port, scan cycle strobe, RAM test engine and
 * communication requester run on clk; module_ready and wire_break are pins.
 */
`timescale 1ns/1ps

// Notes on behaviour
// [R1] Each clock pulse bit is a square wave with equal high and low time.
// [R2] Eight fixed periods, fastest 0.1 s, slowest 2 s.
// [R3] Clock pulse memory writes only when enabled; off after reset; target byte set.
// [R4] Target memory byte is selectable 0 to 255, default 0.
// [R5] A scan cycle longer than the limit (1..6000 ms, default 150) forces STOP.
// [R6] Communication share capped at 10..50 percent, default 20; OS services uncapped.
// [R7] Cyclic RAM self-test extension is fixed at zero.
// [R8] When enabled (default off), internal RAM is tested at every power on.
// [R9] Only complete restart is supported as startup type.
// [R10] Parameter distribution bounded by 1..10000 units of 100 ms, default 100.
// [R11] Modules must report ready within up to 65000 ms, else stay in STOP.
// [R12] Configuring party should choose the largest timeouts when unsure.
// [R13] Diagnostics record program errors, module failures and wire breaks.
// [R14] Bit 0 has the shortest period, rising monotonically to bit 7.
module ccw_cycle_watch #(
    parameter int MS_CYCLES = ccw_pkg::MS_TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Register port.
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rdata,
    // Clock pulse byte memory port.
    output logic             mem_we,
    output logic      [7:0]  mem_addr,
    output logic      [7:0]  mem_wdata,
    // Program execution.
    input  wire logic        cycle_start,
    input  wire logic        prog_error,
    output logic             run,
    // Communication load.
    input  wire logic        comm_req,
    output logic             comm_grant,
    // Startup and rack modules.
    output logic             ram_test_req,
    input  wire logic        ram_test_done,
    input  wire logic        ram_test_fail,
    output logic             param_req,
    input  wire logic        param_done,
    input  wire logic        module_fail,
    input  wire logic        module_ready,
    input  wire logic        wire_break
);

    if (MS_CYCLES < 2 || MS_CYCLES > 32768) begin : g_bad_ms
        $error("MS_CYCLES out of range");
    end

    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers.
    logic [1:0] rst_q;
    logic       rst_n_s;
    logic [1:0] pin_q1;
    logic [1:0] pin_q2;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n_s = rst_q[1];

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pin_q1 <= 2'h0;
            pin_q2 <= 2'h0;
        end else begin
            pin_q1 <= {wire_break, module_ready};
            pin_q2 <= pin_q1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick.
    logic [14:0] ms_cnt;
    logic [14:0] next_ms_cnt;
    logic        ms_tick;

    assign ms_tick = (ms_cnt == 15'(MS_CYCLES - 1));
    always_comb begin
        next_ms_cnt = ms_tick ? 15'h0000 : ms_cnt + 15'h0001;
    end
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            ms_cnt <= 15'h0000;
        end else begin
            ms_cnt <= next_ms_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock pulse byte. All counters start together, so every edge of a slow bit
    // lines up with an edge of bit 0.
    logic [7:0]      pulse;
    logic [7:0][9:0] cpb_cnt;

    for (genvar i = 0; i < 8; i++) begin : g_cpb
        logic       wrap;
        logic [9:0] next_cnt;
        logic       next_bit;
        assign wrap = ms_tick && (cpb_cnt[i] == ccw_pkg::CPB_HALF_MS[i] - 10'h001);
        always_comb begin
            next_cnt = cpb_cnt[i];
            next_bit = pulse[i];
            if (wrap) begin // see [R1] [R2] [R14]
                next_cnt = 10'h000;
                next_bit = !pulse[i];
            end else if (ms_tick) begin
                next_cnt = cpb_cnt[i] + 10'h001;
            end
        end
        always_ff @(posedge clk or negedge rst_n_s) begin
            if (!rst_n_s) begin
                cpb_cnt[i] <= 10'h000;
                pulse[i]   <= 1'b0;
            end else begin
                cpb_cnt[i] <= next_cnt;
                pulse[i]   <= next_bit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    logic        cpb_en, hw_test_en, start;
    logic [7:0]  clk_byte;
    logic [12:0] scan_lim;
    logic [5:0]  comm_pct;
    logic [15:0] param_to, ready_to;
    logic        next_cpb_en, next_hw_test_en;
    logic [7:0]  next_clk_byte;
    logic [12:0] next_scan_lim;
    logic [5:0]  next_comm_pct;
    logic [15:0] next_param_to, next_ready_to;

    assign start = wr_en && (addr == ccw_pkg::A_CTRL) && wdata[ccw_pkg::F_START];

    always_comb begin
        next_cpb_en     = cpb_en;
        next_hw_test_en = hw_test_en;
        next_clk_byte   = clk_byte;
        next_scan_lim   = scan_lim;
        next_comm_pct   = comm_pct;
        next_param_to   = param_to;
        next_ready_to   = ready_to;
        if (wr_en && addr == ccw_pkg::A_CTRL) begin
            next_cpb_en     = wdata[ccw_pkg::F_CPB_EN]; // see [R3]
            next_hw_test_en = wdata[ccw_pkg::F_HWTEST]; // see [R8]
        end else if (wr_en && addr == ccw_pkg::A_CLK_BYTE) begin
            next_clk_byte = wdata[7:0]; // see [R4]
        end else if (wr_en && addr == ccw_pkg::A_SCAN_LIM) begin
            if (in_range(wdata[15:0], 16'(ccw_pkg::MIN_SCAN_LIM), 16'(ccw_pkg::MAX_SCAN_LIM))) begin // see [R5]
                next_scan_lim = wdata[12:0];
            end
        end else if (wr_en && addr == ccw_pkg::A_COMM_PCT) begin
            if (in_range(wdata[15:0], 16'(ccw_pkg::MIN_COMM_PCT), 16'(ccw_pkg::MAX_COMM_PCT))) begin // see [R6]
                next_comm_pct = wdata[5:0];
            end
        end else if (wr_en && addr == ccw_pkg::A_PARAM_TO) begin
            if (in_range(wdata[15:0], ccw_pkg::MIN_PARAM_TO, ccw_pkg::MAX_PARAM_TO)) begin // see [R10]
                next_param_to = wdata[15:0];
            end
        end else if (wr_en && addr == ccw_pkg::A_READY_TO) begin
            if (in_range(wdata[15:0], ccw_pkg::MIN_READY_TO, ccw_pkg::MAX_READY_TO)) begin // see [R11]
                next_ready_to = wdata[15:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            cpb_en     <= 1'b0;
            hw_test_en <= 1'b0;
            clk_byte   <= ccw_pkg::RST_CLK_BYTE;
            scan_lim   <= ccw_pkg::RST_SCAN_LIM;
            comm_pct   <= ccw_pkg::RST_COMM_PCT;
            param_to   <= ccw_pkg::RST_PARAM_TO;
            ready_to   <= ccw_pkg::RST_READY_TO;
        end else begin
            cpb_en     <= next_cpb_en;
            hw_test_en <= next_hw_test_en;
            clk_byte   <= next_clk_byte;
            scan_lim   <= next_scan_lim;
            comm_pct   <= next_comm_pct;
            param_to   <= next_param_to;
            ready_to   <= next_ready_to;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Startup sequencer, scan watchdog and communication budget.
    ccw_pkg::ccw_state_t state, next_state;
    logic [15:0] st_cnt, next_st_cnt;
    logic [6:0]  sub_ms, next_sub_ms;
    logic [12:0] scan_ms, next_scan_ms;
    logic [6:0]  win_ms, next_win_ms;
    logic [5:0]  comm_used, next_comm_used;
    logic        unit_tick, tmo_hit, overrun;

    assign unit_tick = ms_tick && (sub_ms == 7'(ccw_pkg::UNIT_MS - 1));
    assign tmo_hit   = (state == ccw_pkg::ST_PARAM) ? (unit_tick && st_cnt == param_to - 16'h0001)
                                                    : (ms_tick && st_cnt == ready_to - 16'h0001);
    assign overrun   = ms_tick && !cycle_start && (scan_ms == scan_lim); // see [R5]
    // The budget only gates the requester; OS data preparation is not routed here.
    assign comm_grant = comm_req && run && (comm_used < comm_pct); // see [R6]

    always_comb begin
        next_state     = state;
        next_st_cnt    = tmo_hit ? st_cnt : st_cnt + 16'h0001;
        next_sub_ms    = unit_tick ? 7'h00 : sub_ms + 7'h01;
        if (!ms_tick) begin
            next_sub_ms = sub_ms;
        end
        if (!((state == ccw_pkg::ST_PARAM) ? unit_tick : ms_tick)) begin
            next_st_cnt = st_cnt;
        end
        next_scan_ms   = cycle_start ? 13'h0000 : (ms_tick ? scan_ms + 13'h0001 : scan_ms);
        next_win_ms    = win_ms;
        next_comm_used = (comm_grant && ms_tick) ? comm_used + 6'h01 : comm_used;
        if (ms_tick) begin
            next_win_ms = win_ms + 7'h01;
            if (win_ms == 7'(ccw_pkg::COMM_WINDOW_MS - 1)) begin
                next_win_ms    = 7'h00;
                next_comm_used = 6'h00;
            end
        end
        case (state)
            ccw_pkg::ST_IDLE, ccw_pkg::ST_STOP: begin
                // Any start is a complete restart from a clean sequence.
                if (start) begin // see [R9]
                    // The test bit written beside start counts, so one write both arms and starts.
                    next_state = wdata[ccw_pkg::F_HWTEST] ? ccw_pkg::ST_RAMTEST : ccw_pkg::ST_PARAM; // see [R8]
                end
            end
            ccw_pkg::ST_RAMTEST: begin
                if (ram_test_done) begin
                    next_state = ram_test_fail ? ccw_pkg::ST_STOP : ccw_pkg::ST_PARAM;
                end
            end
            ccw_pkg::ST_PARAM: begin
                if (param_done) begin
                    next_state = ccw_pkg::ST_READY;
                end else if (tmo_hit) begin // see [R10]
                    next_state = ccw_pkg::ST_STOP;
                end
            end
            ccw_pkg::ST_READY: begin
                if (pin_q2[0]) begin
                    next_state = ccw_pkg::ST_RUN;
                end else if (tmo_hit) begin // see [R11]
                    next_state = ccw_pkg::ST_STOP;
                end
            end
            ccw_pkg::ST_RUN: begin
                if (overrun) begin
                    next_state = ccw_pkg::ST_STOP;
                end
            end
            default: begin
                next_state = ccw_pkg::ST_STOP;
            end
        endcase
        if (next_state != state) begin
            next_st_cnt  = 16'h0000;
            next_sub_ms  = 7'h00;
            next_scan_ms = 13'h0000;
        end
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            state     <= ccw_pkg::ST_IDLE;
            st_cnt    <= 16'h0000;
            sub_ms    <= 7'h00;
            scan_ms   <= 13'h0000;
            win_ms    <= 7'h00;
            comm_used <= 6'h00;
        end else begin
            state     <= next_state;
            st_cnt    <= next_st_cnt;
            sub_ms    <= next_sub_ms;
            scan_ms   <= next_scan_ms;
            win_ms    <= next_win_ms;
            comm_used <= next_comm_used;
        end
    end

    assign run          = (state == ccw_pkg::ST_RUN);
    assign ram_test_req = (state == ccw_pkg::ST_RAMTEST);
    assign param_req    = (state == ccw_pkg::ST_PARAM);

    ////////////////////////////////////////////////////////////////////////////
    // Diagnostics, memory write and read data.
    logic [ccw_pkg::D_NUM-1:0] diag, next_diag, diag_set;
    logic        next_mem_we;
    logic [7:0]  next_mem_addr, next_mem_wdata;
    logic [31:0] next_rdata;

    always_comb begin
        diag_set = '0;
        diag_set[ccw_pkg::D_SCAN]    = run && overrun;
        diag_set[ccw_pkg::D_PARAM]   = (state == ccw_pkg::ST_PARAM) && !param_done && tmo_hit;
        diag_set[ccw_pkg::D_READY]   = (state == ccw_pkg::ST_READY) && !pin_q2[0] && tmo_hit;
        diag_set[ccw_pkg::D_RAM]     = ram_test_req && ram_test_done && ram_test_fail;
        diag_set[ccw_pkg::D_PROG]    = prog_error; // see [R13]
        diag_set[ccw_pkg::D_MODFAIL] = module_fail;
        diag_set[ccw_pkg::D_WIRE]    = pin_q2[1];
        // A flag raised in the cycle it is cleared stays set.
        next_diag = diag;
        if (wr_en && addr == ccw_pkg::A_DIAG) begin
            next_diag = diag & ~wdata[ccw_pkg::D_NUM-1:0];
        end
        next_diag = next_diag | diag_set; // see [R13]
        // The byte is refreshed each ms so a new target byte is filled within one ms.
        next_mem_we    = cpb_en && ms_tick; // see [R3]
        next_mem_addr  = clk_byte;
        next_mem_wdata = pulse;
        next_rdata     = 32'h0000_0000;
        if (rd_en && addr == ccw_pkg::A_CTRL) begin
            next_rdata = {30'h0, hw_test_en, cpb_en};
        end else if (rd_en && addr == ccw_pkg::A_CLK_BYTE) begin
            next_rdata = {24'h0, clk_byte};
        end else if (rd_en && addr == ccw_pkg::A_SCAN_LIM) begin
            next_rdata = {19'h0, scan_lim};
        end else if (rd_en && addr == ccw_pkg::A_COMM_PCT) begin
            next_rdata = {26'h0, comm_pct};
        end else if (rd_en && addr == ccw_pkg::A_SELFTEST) begin
            next_rdata = 32'h0000_0000; // see [R7]
        end else if (rd_en && addr == ccw_pkg::A_PARAM_TO) begin
            next_rdata = {16'h0, param_to};
        end else if (rd_en && addr == ccw_pkg::A_READY_TO) begin
            next_rdata = {16'h0, ready_to};
        end else if (rd_en && addr == ccw_pkg::A_STATUS) begin
            next_rdata = {16'h0, pulse, 4'h0, state, run};
        end else if (rd_en && addr == ccw_pkg::A_DIAG) begin
            next_rdata = {25'h0, diag};
        end
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            diag      <= '0;
            mem_we    <= 1'b0;
            mem_addr  <= 8'h00;
            mem_wdata <= 8'h00;
            rdata     <= 32'h0000_0000;
        end else begin
            diag      <= next_diag;
            mem_we    <= next_mem_we;
            mem_addr  <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
            rdata     <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_s);

    sequence s_param_expire;
        (state == ccw_pkg::ST_PARAM) && tmo_hit && !param_done;
    endsequence

    a_pulse_toggle: assert property (g_cpb[0].wrap |=> pulse[0] != $past(pulse[0])) // see [R1]
        else $error("bit 0 did not toggle at its half period");
    a_pulse_align: assert property ($changed(pulse[7]) |-> $changed(pulse[0])) // see [R14]
        else $error("slow pulse bit changed without bit 0");
    a_mem_write: assert property (mem_we |-> $past(cpb_en) && mem_wdata == $past(pulse) && mem_addr == $past(clk_byte)) // see [R3]
        else $error("memory write without enable or wrong data");
    a_scan_stop: assert property (run && overrun |=> state == ccw_pkg::ST_STOP ##0 diag[ccw_pkg::D_SCAN]) // see [R5]
        else $error("scan overrun did not force stop");
    a_comm_cap: assert property (comm_grant |-> comm_used < comm_pct && run) // see [R6]
        else $error("communication granted over budget");
    a_selftest_zero: assert property (rd_en && addr == ccw_pkg::A_SELFTEST |=> rdata == 32'h0000_0000) // see [R7]
        else $error("self-test extension not zero");
    a_ramtest_entry: assert property ((state == ccw_pkg::ST_IDLE || state == ccw_pkg::ST_STOP) && start // see [R8]
        && wdata[ccw_pkg::F_HWTEST] |=> ram_test_req)
        else $error("power-on RAM test skipped");
    a_param_tmo: assert property (s_param_expire |=> state == ccw_pkg::ST_STOP ##1 state == ccw_pkg::ST_STOP || start) // see [R10]
        else $error("parameter timeout did not stop");
    a_ready_run: assert property (state == ccw_pkg::ST_READY && pin_q2[0] |=> run) // see [R11]
        else $error("ready modules did not lead to run");
    a_diag_sticky: assert property (diag_set[ccw_pkg::D_PROG] |=> diag[ccw_pkg::D_PROG]) // see [R13]
        else $error("program error flag lost");

endmodule

/* bench/ccw_rack_model.sv */
/* Rack model: the RAM tester and the I/O modules that answer the startup sequencer.
 * Assumes one clock; the bench sets the answer delay and the faults. */
`timescale 1ns/1ps
module ccw_rack_model (
    // Clock and steering.
    input  wire logic       clk,
    input  wire logic [7:0] dly,
    input  wire logic       fail_ram,
    input  wire logic       hold_param,
    input  wire logic       hold_ready,
    // Startup handshakes.
    input  wire logic       ram_test_req,
    output logic            ram_test_done,
    output logic            ram_test_fail,
    input  wire logic       param_req,
    output logic            param_done,
    output logic            module_ready
);
    logic [7:0] cnt = 8'h00;
    initial begin
        ram_test_done = 1'h0;
        ram_test_fail = 1'h0;
        param_done    = 1'h0;
        module_ready  = 1'h0;
    end
    // The result toggles outside its valid cycle, so a stale value is never trusted.
    always @(posedge clk) begin
        cnt           <= (ram_test_req || param_req) ? cnt + 8'h01 : 8'h00;
        ram_test_done <= ram_test_req && cnt == dly;
        ram_test_fail <= (ram_test_req && cnt == dly) ? fail_ram : !ram_test_fail;
        param_done    <= param_req && cnt == dly && !hold_param;
        if (param_done && !hold_ready)
            module_ready <= 1'h1;
        else if (ram_test_req || param_req)
            module_ready <= 1'h0;
    end
endmodule

/* bench/ccw_cycle_watch_test.sv */
/* Bench for the cycle watch block: register defaults and ranges, clock pulse byte,
 * startup, scan watchdog, communication cap and diagnostics.
 * Assumes the rack model on the startup lines and a 20-cycle ms tick. */
`timescale 1ns/1ps
module ccw_cycle_watch_test;
    localparam int MS = 20;
    typedef struct {
        logic        wr;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } ccw_row_t;
    logic        clk = 1'h0;
    logic        rstn, wr_en, rd_en, mem_we, cycle_start, run, comm_req, comm_grant;
    logic        ram_test_req, ram_test_done, ram_test_fail, param_req, param_done, module_ready;
    logic        fail_ram, hold_param, hold_ready, cs_on, mon, saw_ram;
    logic [2:0]  ev;
    logic [7:0]  addr, mem_addr, mem_wdata, dly, prev;
    logic [31:0] wdata, rdata, v;
    int          n_mismatch, checks_done, ms_n, g_cnt, we_cnt, cs_cnt;
    int          chg [8];
    bit          vld [8];
    ccw_row_t    rows [16] = '{
        '{1'h0, ccw_pkg::A_CTRL,     32'h0,    32'h0},
        '{1'h0, ccw_pkg::A_CLK_BYTE, 32'h0,    32'h0},
        '{1'h0, ccw_pkg::A_SCAN_LIM, 32'h0,    32'h96},
        '{1'h0, ccw_pkg::A_COMM_PCT, 32'h0,    32'h14},
        '{1'h0, ccw_pkg::A_SELFTEST, 32'h0,    32'h0},
        '{1'h0, ccw_pkg::A_PARAM_TO, 32'h0,    32'h64},
        '{1'h0, ccw_pkg::A_READY_TO, 32'h0,    32'hfde8},
        '{1'h1, 8'h24,               32'h1,    32'h0},
        '{1'h1, ccw_pkg::A_SCAN_LIM, 32'h1771, 32'h96},
        '{1'h1, ccw_pkg::A_SCAN_LIM, 32'h1770, 32'h1770},
        '{1'h1, ccw_pkg::A_COMM_PCT, 32'h9,    32'h14},
        '{1'h1, ccw_pkg::A_COMM_PCT, 32'h33,   32'h14},
        '{1'h1, ccw_pkg::A_COMM_PCT, 32'h32,   32'h32},
        '{1'h1, ccw_pkg::A_PARAM_TO, 32'h2711, 32'h64},
        '{1'h1, ccw_pkg::A_READY_TO, 32'h0,    32'hfde8},
        '{1'h1, ccw_pkg::A_SELFTEST, 32'h5,    32'h0}
    };

    ccw_cycle_watch #(.MS_CYCLES(MS)) dut (.*, .prog_error(ev[0]), .module_fail(ev[1]), .wire_break(ev[2]));
    ccw_rack_model rack (.*);

    always #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_en <= 1'h1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        rd_en <= 1'h1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'h0;
        #1 v = rdata;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Scan cycle marks every ms while enabled; the watchdog case simply stops them.
    always @(posedge clk) begin
        cs_cnt      <= (cs_cnt == MS - 1) ? 0 : cs_cnt + 1;
        cycle_start <= cs_on && cs_cnt == 0;
        if (ram_test_req === 1'h1)
            saw_ram = 1'h1;
        if (comm_grant === 1'h1)
            g_cnt++;
        if (mem_we === 1'h1)
            we_cnt++;
        if (mem_we === 1'h1 && mon) begin
            chk("clock byte target", 32'h5a, 32'(mem_addr));
            for (int i = 0; i < 8; i++) begin
                if (ms_n > 0 && mem_wdata[i] !== prev[i]) begin
                    if (vld[i])
                        chk("clock bit half period", 32'(ccw_pkg::CPB_HALF_MS[i]), ms_n - chg[i]);
                    chg[i] = ms_n;
                    vld[i] = 1'b1;
                end
            end
            prev = mem_wdata;
            ms_n++;
        end
    end
    initial begin
        #3000000;
        n_mismatch++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rstn, wr_en, rd_en, comm_req, fail_ram, hold_param, hold_ready, cs_on, mon, saw_ram} = 10'h0;
        {ev, addr, wdata, dly} = 51'h0;
        wt(3);
        rstn <= 1'h1;
        wt(4);
        foreach (rows[i]) begin
            if (rows[i].wr)
                wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk("register readback", rows[i].e, v);
        end
        dly <= 8'hc8;
        wr(ccw_pkg::A_CLK_BYTE, 32'h5a);
        wr(ccw_pkg::A_SCAN_LIM, 32'h3);
        wr(ccw_pkg::A_COMM_PCT, 32'ha);
        cs_on    <= 1'h1;
        comm_req <= 1'h1;
        wr(ccw_pkg::A_CTRL, 32'h7);
        for (int i = 0; i < 2000 && run !== 1'h1; i++)
            @(posedge clk);
        chk("ram test before run", 32'h1, 32'(saw_ram));
        rd(ccw_pkg::A_STATUS);
        chk("status in run", 32'h9, 32'(v[3:0]));
        g_cnt = 0;
        mon <= 1'h1;
        wt(1000 * MS);
        chk("grant share", 32'h1, 32'(g_cnt >= 90 * MS && g_cnt <= 110 * MS));
        wt(1100 * MS);
        chk("slowest bit toggled", 32'h1, 32'(vld[7]));
        mon      <= 1'h0;
        comm_req <= 1'h0;
        wr(ccw_pkg::A_CTRL, 32'h0);
        wt(2);
        we_cnt = 0;
        wt(5 * MS);
        chk("no clock writes when off", 32'h0, we_cnt);
        do begin
            @(posedge clk);
            #1;
        end while (cycle_start !== 1'h1);
        @(posedge clk) cs_on <= 1'h0;
        wt(MS);
        #1 chk("run before limit", 32'h1, 32'(run));
        wt(4 * MS);
        #1 chk("stop after overrun", 32'h0, 32'(run));
        rd(ccw_pkg::A_DIAG);
        chk("overrun flag", 32'h1, v);
        wr(ccw_pkg::A_DIAG, 32'h7f);
        rd(ccw_pkg::A_DIAG);
        chk("flags cleared", 32'h0, v);
        // A withheld parameter answer must end in stop after 100 ms.
        hold_param <= 1'h1;
        dly        <= 8'h2;
        saw_ram = 1'h0;
        wr(ccw_pkg::A_PARAM_TO, 32'h1);
        wr(ccw_pkg::A_CTRL, 32'h4);
        wt(90 * MS);
        #1 chk("parameters pending", 32'h1, 32'(param_req));
        wt(20 * MS);
        #1 chk("parameters timed out", 32'h0, 32'(param_req));
        rd(ccw_pkg::A_DIAG);
        chk("parameter timeout flag", 32'h2, v);
        chk("no ram test when off", 32'h0, 32'(saw_ram));
        hold_param <= 1'h0;
        hold_ready <= 1'h1;
        wr(ccw_pkg::A_DIAG, 32'h7f);
        wr(ccw_pkg::A_READY_TO, 32'h2);
        wr(ccw_pkg::A_CTRL, 32'h4);
        wt(10 * MS);
        rd(ccw_pkg::A_STATUS);
        chk("stays in stop", 32'ha, 32'(v[3:0]));
        rd(ccw_pkg::A_DIAG);
        chk("ready timeout flag", 32'h4, v);
        hold_ready <= 1'h0;
        fail_ram   <= 1'h1;
        wr(ccw_pkg::A_DIAG, 32'h7f);
        wr(ccw_pkg::A_CTRL, 32'h6);
        wt(MS);
        rd(ccw_pkg::A_DIAG);
        chk("ram fail flag", 32'h8, v);
        for (int i = 0; i < 3; i++) begin
            wr(ccw_pkg::A_DIAG, 32'h7f);
            ev <= 3'h1 << i;
            wt(1);
            ev <= 3'h0;
            wt(4);
            rd(ccw_pkg::A_DIAG);
            chk("event flag", 32'h10 << i, v);
        end
        final_report();
    end
endmodule
